// ==== verilog/lble_params.svh ====
// Constants for the ladder bit logic engine: area layout, ranges, reset values and timing.
// Assumes a 25 MHz core clock and the opcode encoding held in lble_pkg.
//
// Overview of operation
// - Load starts a new logic line; condition becomes the operand bit.
// - Inverted load starts a new line; condition becomes the inverted operand bit.
// - Series contact ANDs the operand bit into the condition.
// - Inverted series contact ANDs the inverted operand bit into the condition.
// - Parallel contact ORs the operand bit into the condition.
// - Inverted parallel contact ORs the inverted operand bit into the condition.
// - Block series merge ANDs the two most recent logic blocks.
// - Block parallel merge ORs the two most recent logic blocks.
// - Coil writes the condition to the addressed bit.
// - Inverted coil writes the inverted condition to the addressed bit.
// - Down counter with preset 0 to 9999, count pulse, reset; constant number.
// - On-delay timer counts down tenths of seconds from preset 000.0 to 999.9.
// - Data memory words 1000 to 1999 are read only; 0000 to 0999 writable.
`ifndef LBLE_PARAMS_SVH
`define LBLE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Areas
// ----------------------------------------------------------------------------
`define LBLE_BIT_AW         14
`define LBLE_TC_NW          9
`define LBLE_TC_COUNT       512
`define LBLE_TC_BIT_BASE    14'h3E00
`define LBLE_DM_AW          11
`define LBLE_DM_WORDS       2000
`define LBLE_DM_RO_FIRST    11'h3E8
`define LBLE_WORD_W         16
`define LBLE_PV_W           14
`define LBLE_PRESET_MAX     14'h270F
`define LBLE_STACK_DEPTH    8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LBLE_COND_RST       1'b0
`define LBLE_STACK_RST      8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LBLE_CLK_PERIOD_NS  40
`define LBLE_TENTH_NS       100000000
`define LBLE_TICK_CNT_W     22

`endif

// ==== verilog/lble_pkg.sv ====
// Types shared by the ladder bit logic engine files.
// Assumes nothing beyond a SystemVerilog compiler.
package lble_pkg;

   typedef enum logic [3:0] {
      LBLE_OP_NOP      = 4'h0,
      LBLE_OP_LOAD     = 4'h1,
      LBLE_OP_LOAD_INV = 4'h2,
      LBLE_OP_AND      = 4'h3,
      LBLE_OP_AND_INV  = 4'h4,
      LBLE_OP_OR       = 4'h5,
      LBLE_OP_OR_INV   = 4'h6,
      LBLE_OP_BLK_AND  = 4'h7,
      LBLE_OP_BLK_OR   = 4'h8,
      LBLE_OP_COIL     = 4'h9,
      LBLE_OP_COIL_INV = 4'hA,
      LBLE_OP_COUNTER  = 4'hB,
      LBLE_OP_TIMER    = 4'hC,
      LBLE_OP_STORE_DM = 4'hD,
      LBLE_OP_SCAN_END = 4'hE
   } lble_op_t;

   typedef enum logic {
      LBLE_ST_IDLE = 1'b0,
      LBLE_ST_EXEC = 1'b1
   } lble_state_t;

endpackage

// ==== verilog/lble_mem.sv ====
// Simple dual-port memory with registered read data.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none

module lble_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2000,
   parameter int AW    = 11
) (
   input  wire logic             clk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem_array [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem_array[waddr] <= wdata;
      end
      rdata <= mem_array[raddr];
   end

endmodule // lble_mem

`default_nettype wire

// ==== verilog/lble_engine.sv ====
// Ladder bit logic engine: executes one basic instruction per two clocks.
// Assumes the instruction source holds its inputs while READY_OUT is low.
`timescale 1ns/1ps
`default_nettype none
`include "lble_params.svh"

module lble_engine
   import lble_pkg::*;
#(
   parameter int BIT_AW      = `LBLE_BIT_AW,
   parameter int TC_NW       = `LBLE_TC_NW,
   parameter int DM_AW       = `LBLE_DM_AW,
   parameter int STACK_DEPTH = `LBLE_STACK_DEPTH,
   parameter int TICK_CYCLES = `LBLE_TENTH_NS / `LBLE_CLK_PERIOD_NS
) (
   input  wire logic                    CORE_CLK_IN,
   input  wire logic                    RESET_N_IN,
   input  wire logic                    INSTR_VALID_IN,
   input  wire logic [3:0]              INSTR_OP_IN,
   input  wire logic [BIT_AW-1:0]       BIT_ADDR_IN,
   input  wire logic [TC_NW-1:0]        TC_NUM_IN,
   input  wire logic [`LBLE_WORD_W-1:0] PRESET_IN,
   input  wire logic                    PRESET_FROM_DM_IN,
   input  wire logic [DM_AW-1:0]        DM_ADDR_IN,
   output logic                         READY_OUT,
   output logic                         EXEC_DONE_OUT,
   output logic                         COND_OUT,
   output logic                         WRITE_REFUSED_OUT
);

   localparam int PV_W = `LBLE_PV_W;

   // -------------------------------------------------------------------------
   // Instruction capture
   // -------------------------------------------------------------------------
   lble_state_t               state_reg;
   lble_state_t               state_next;
   lble_op_t                  op_reg;
   logic [BIT_AW-1:0]         bit_addr_reg;
   logic [TC_NW-1:0]          tc_num_reg;
   logic [`LBLE_WORD_W-1:0]   preset_reg;
   logic                      from_dm_reg;
   logic [DM_AW-1:0]          dm_addr_reg;
   logic                      cond_reg;
   logic                      cond_next;
   logic [STACK_DEPTH-1:0]    stack_reg;
   logic [STACK_DEPTH-1:0]    stack_next;

   wire accept   = (state_reg == LBLE_ST_IDLE) && INSTR_VALID_IN;
   wire in_exec  = (state_reg == LBLE_ST_EXEC);

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         state_reg <= LBLE_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LBLE_ST_IDLE: begin
            if (INSTR_VALID_IN) begin
               state_next = LBLE_ST_EXEC;
            end
         end
         LBLE_ST_EXEC: begin
            state_next = LBLE_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         op_reg       <= LBLE_OP_NOP;
         bit_addr_reg <= '0;
         tc_num_reg   <= '0;
         preset_reg   <= '0;
         from_dm_reg  <= 1'b0;
         dm_addr_reg  <= '0;
      end else if (accept) begin
         op_reg       <= lble_op_t'(INSTR_OP_IN);
         bit_addr_reg <= BIT_ADDR_IN;
         tc_num_reg   <= TC_NUM_IN;
         preset_reg   <= PRESET_IN;
         from_dm_reg  <= PRESET_FROM_DM_IN;
         dm_addr_reg  <= DM_ADDR_IN;
      end
   end

   // -------------------------------------------------------------------------
   // Tenth-second time base
   // -------------------------------------------------------------------------
   // A tick seen at any time during a scan lets every timer of the next scan step once.
   logic [`LBLE_TICK_CNT_W-1:0] tick_cnt_reg;
   logic                        tick_pend_reg;
   logic                        tick_scan_reg;

   wire tick      = (tick_cnt_reg == `LBLE_TICK_CNT_W'(TICK_CYCLES - 1));
   wire scan_end  = in_exec && (op_reg == LBLE_OP_SCAN_END);

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         tick_cnt_reg  <= '0;
         tick_pend_reg <= 1'b0;
         tick_scan_reg <= 1'b0;
      end else begin
         tick_cnt_reg  <= tick ? '0 : tick_cnt_reg + 1'b1;
         if (scan_end) begin
            tick_scan_reg <= tick_pend_reg | tick;
            tick_pend_reg <= 1'b0;
         end else if (tick) begin
            tick_pend_reg <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Operand areas
   // -------------------------------------------------------------------------
   logic                    bit_rdata;
   logic                    bit_we;
   logic [BIT_AW-1:0]       bit_waddr;
   logic                    bit_wdata;
   logic [PV_W:0]           tc_rdata;
   logic                    tc_we;
   logic [PV_W:0]           tc_wdata;
   logic [`LBLE_WORD_W-1:0] dm_rdata;
   logic                    dm_we;

   lble_mem #(.WIDTH(1), .DEPTH(2 ** BIT_AW), .AW(BIT_AW)) u_bit_area (
      .clk   (CORE_CLK_IN),
      .we    (bit_we),
      .waddr (bit_waddr),
      .wdata (bit_wdata),
      .raddr (BIT_ADDR_IN),
      .rdata (bit_rdata)
   );

   // Each entry holds the previous enable/pulse level above the present value
   lble_mem #(.WIDTH(PV_W + 1), .DEPTH(2 ** TC_NW), .AW(TC_NW)) u_tc_area (
      .clk   (CORE_CLK_IN),
      .we    (tc_we),
      .waddr (tc_num_reg),
      .wdata (tc_wdata),
      .raddr (TC_NUM_IN),
      .rdata (tc_rdata)
   );

   lble_mem #(.WIDTH(`LBLE_WORD_W), .DEPTH(`LBLE_DM_WORDS), .AW(DM_AW)) u_dm_area (
      .clk   (CORE_CLK_IN),
      .we    (dm_we),
      .waddr (dm_addr_reg),
      .wdata (preset_reg),
      .raddr (DM_ADDR_IN),
      .rdata (dm_rdata)
   );

   // -------------------------------------------------------------------------
   // Contact logic and block stack
   // -------------------------------------------------------------------------
   wire is_load   = (op_reg == LBLE_OP_LOAD) || (op_reg == LBLE_OP_LOAD_INV);
   wire is_merge  = (op_reg == LBLE_OP_BLK_AND) || (op_reg == LBLE_OP_BLK_OR);
   wire is_tc     = (op_reg == LBLE_OP_COUNTER) || (op_reg == LBLE_OP_TIMER);
   wire stack_top = stack_reg[0];
   wire [STACK_DEPTH-1:0] stack_push = {stack_reg[STACK_DEPTH-2:0], cond_reg};
   wire [STACK_DEPTH-1:0] stack_pop  = {1'b0, stack_reg[STACK_DEPTH-1:1]};

   wire tc_done;

   always_comb begin
      cond_next  = cond_reg;
      stack_next = stack_reg;
      unique case (op_reg)
         LBLE_OP_LOAD:     cond_next = bit_rdata;
         LBLE_OP_LOAD_INV: cond_next = ~bit_rdata;
         LBLE_OP_AND:      cond_next = cond_reg & bit_rdata;
         LBLE_OP_AND_INV:  cond_next = cond_reg & ~bit_rdata;
         LBLE_OP_OR:       cond_next = cond_reg | bit_rdata;
         LBLE_OP_OR_INV:   cond_next = cond_reg | ~bit_rdata;
         LBLE_OP_BLK_AND:  cond_next = stack_top & cond_reg;
         LBLE_OP_BLK_OR:   cond_next = stack_top | cond_reg;
         LBLE_OP_COUNTER:  cond_next = tc_done;
         LBLE_OP_TIMER:    cond_next = tc_done;
         default:          cond_next = cond_reg;
      endcase
      if (is_load) begin
         stack_next = stack_push;
      end else if (is_merge || op_reg == LBLE_OP_COUNTER) begin
         stack_next = stack_pop;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         cond_reg  <= `LBLE_COND_RST;
         stack_reg <= `LBLE_STACK_RST;
      end else if (in_exec) begin
         cond_reg  <= cond_next;
         stack_reg <= stack_next;
      end
   end

   // -------------------------------------------------------------------------
   // Timers and counters
   // -------------------------------------------------------------------------
   // Counter: pulse is the earlier block, reset is the current condition
   wire [`LBLE_WORD_W-1:0] preset_raw = from_dm_reg ? dm_rdata : preset_reg;
   wire preset_over = (preset_raw > `LBLE_WORD_W'(`LBLE_PRESET_MAX));
   wire [PV_W-1:0] preset_val = preset_over ? `LBLE_PRESET_MAX : preset_raw[PV_W-1:0];
   wire [PV_W-1:0] pv_now     = tc_rdata[PV_W-1:0];
   wire            level_prev = tc_rdata[PV_W];
   wire            pv_zero    = (pv_now == '0);
   wire            is_counter = (op_reg == LBLE_OP_COUNTER);
   wire            cnt_reset  = cond_reg;
   wire            cnt_pulse  = stack_top;
   wire            cnt_edge   = cnt_pulse && !level_prev;
   wire            tim_enable = cond_reg;
   wire            tc_level   = is_counter ? cnt_pulse : tim_enable;
   wire            tc_load    = is_counter ? cnt_reset : !tim_enable;
   wire            tc_step    = is_counter ? cnt_edge : tick_scan_reg;
   wire [PV_W-1:0] pv_dec     = pv_now - 1'b1;
   wire [PV_W-1:0] pv_next    = tc_load ? preset_val :
                                (tc_step && !pv_zero) ? pv_dec : pv_now;

   assign tc_done  = !tc_load && (pv_next == '0);
   assign tc_we    = in_exec && is_tc;
   assign tc_wdata = {tc_level, pv_next};

   // -------------------------------------------------------------------------
   // Output bits and data memory writes
   // -------------------------------------------------------------------------
   wire is_coil   = (op_reg == LBLE_OP_COIL) || (op_reg == LBLE_OP_COIL_INV);
   wire coil_val  = (op_reg == LBLE_OP_COIL) ? cond_reg : ~cond_reg;
   wire [BIT_AW-1:0] tc_bit_addr = `LBLE_TC_BIT_BASE + BIT_AW'(tc_num_reg);

   assign bit_we    = in_exec && (is_coil || is_tc);
   assign bit_waddr = is_tc ? tc_bit_addr : bit_addr_reg;
   assign bit_wdata = is_tc ? tc_done : coil_val;

   wire store_dm  = in_exec && (op_reg == LBLE_OP_STORE_DM);
   wire dm_ro     = (dm_addr_reg >= `LBLE_DM_RO_FIRST);
   assign dm_we   = store_dm && !dm_ro;

   // -------------------------------------------------------------------------
   // Status outputs
   // -------------------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         READY_OUT         <= 1'b0;
         EXEC_DONE_OUT     <= 1'b0;
         COND_OUT          <= `LBLE_COND_RST;
         WRITE_REFUSED_OUT <= 1'b0;
      end else begin
         READY_OUT         <= (state_next == LBLE_ST_IDLE);
         EXEC_DONE_OUT     <= in_exec;
         COND_OUT          <= in_exec ? cond_next : cond_reg;
         WRITE_REFUSED_OUT <= store_dm && dm_ro;
      end
   end

endmodule // lble_engine

`default_nettype wire

// ==== tb/lble_properties.sv ====
// Checker for the ladder bit logic engine: handshake, answer timing, read-only store.
// Assumes it is bound to lble_engine and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module lble_checker
   import lble_pkg::*;
#(
   parameter int DM_AW = 11
) (
   input wire logic             CORE_CLK_IN,
   input wire logic             RESET_N_IN,
   input wire logic             INSTR_VALID_IN,
   input wire logic [3:0]       INSTR_OP_IN,
   input wire logic [DM_AW-1:0] DM_ADDR_IN,
   input wire logic             READY_OUT,
   input wire logic             EXEC_DONE_OUT,
   input wire logic             COND_OUT,
   input wire logic             WRITE_REFUSED_OUT
);
   // -------------------------------------------------------------------------
   // Request decode
   // -------------------------------------------------------------------------
   wire logic take  = READY_OUT && INSTR_VALID_IN;
   wire logic store = take && INSTR_OP_IN == LBLE_OP_STORE_DM;
   wire logic st_ro = store && DM_ADDR_IN >= 11'h3E8;
   wire logic st_rw = store && DM_ADDR_IN < 11'h3E8;

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   // -------------------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------------------
   taken_done_a: assert property (take |-> ##2 EXEC_DONE_OUT)
      else $error("done pulse missing two edges after take");
   ready_gap_a: assert property (take |=> !READY_OUT ##1 READY_OUT)
      else $error("ready not low for exactly one cycle after take");
   done_pulse_a: assert property (EXEC_DONE_OUT |=> !EXEC_DONE_OUT)
      else $error("done pulse longer than one cycle");
   done_cause_a: assert property (EXEC_DONE_OUT |-> $past(take, 2))
      else $error("done without a request two edges before");
   cond_hold_a: assert property (!EXEC_DONE_OUT |-> $stable(COND_OUT))
      else $error("condition changed without a finished instruction");
   refuse_ro_a: assert property (st_ro |-> ##2 WRITE_REFUSED_OUT)
      else $error("store to read-only word not refused");
   store_rw_a: assert property (st_rw |-> ##2 !WRITE_REFUSED_OUT)
      else $error("store to writable word refused");
   refuse_cause_a: assert property (WRITE_REFUSED_OUT |-> EXEC_DONE_OUT && $past(st_ro, 2))
      else $error("refusal without a read-only store");
   reset_ready_a: assert property ($rose(RESET_N_IN) |=> READY_OUT)
      else $error("ready not raised after reset release");

   ro_store_c: cover property (st_ro);
   counter_c: cover property (take && INSTR_OP_IN == LBLE_OP_COUNTER);
   cond_true_c: cover property (EXEC_DONE_OUT && COND_OUT);
endmodule // lble_checker

bind lble_engine lble_checker #(.DM_AW(DM_AW)) u_lble_checker (
   .CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
   .INSTR_OP_IN(INSTR_OP_IN), .DM_ADDR_IN(DM_ADDR_IN), .READY_OUT(READY_OUT),
   .EXEC_DONE_OUT(EXEC_DONE_OUT), .COND_OUT(COND_OUT), .WRITE_REFUSED_OUT(WRITE_REFUSED_OUT)
);
`default_nettype wire

// ==== tb/ladder_bit_logic_engine_test.sv ====
// Self-checking testbench for the ladder bit logic engine.
// Assumes lble_engine, lble_pkg and the bound checker; drives inputs at falling edges.
`timescale 1ns/1ps
`default_nettype none

module ladder_bit_logic_engine_test;
   import lble_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        valid = 1'b0;
   logic [3:0]  op = 4'h0;
   logic [13:0] baddr = 14'h0000;
   logic [8:0]  tcn = 9'h000;
   logic [15:0] preset = 16'h0000;
   logic        from_dm = 1'b0;
   logic [10:0] dmaddr = 11'h000;
   logic        ready, done, cond, refused;
   logic [1:0]  exp_q[$];
   logic        stk[$];
   logic        bits[int];
   logic        lastp[int];
   int          cnt[int];
   int          tim[int];
   bit          tstep = 1'b0;
   int          t_end = 0;
   localparam int TICK = 20;
   int          dm[int];
   logic        m_cond = 1'b0;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cycles = 0;

   always #20 clk = ~clk;

   lble_engine #(.TICK_CYCLES(TICK)) uut (
      .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .INSTR_VALID_IN(valid), .INSTR_OP_IN(op),
      .BIT_ADDR_IN(baddr), .TC_NUM_IN(tcn), .PRESET_IN(preset), .PRESET_FROM_DM_IN(from_dm),
      .DM_ADDR_IN(dmaddr), .READY_OUT(ready), .EXEC_DONE_OUT(done), .COND_OUT(cond),
      .WRITE_REFUSED_OUT(refused)
   );

   // -------------------------------------------------------------------------
   // Reporting
   // -------------------------------------------------------------------------
   task automatic fail(input string m);
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
   endtask

   task automatic stop_test;
      $display("mismatches %0d, compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail("timeout");
         stop_test();
      end
   end

   // Takes the oldest expectation whenever a result appears
   always @(negedge clk) begin
      if (done === 1'b1) begin
         compares++;
         if (exp_q.size() == 0)
            fail("unexpected done");
         else if ({cond, refused} !== exp_q.pop_front())
            fail("condition or refusal");
      end
   end

   // -------------------------------------------------------------------------
   // Driver with reference model
   // -------------------------------------------------------------------------
   task automatic issue(input logic [3:0] o, input int a, input int p = 0, input bit f = 0);
      logic b;
      logic r;
      logic pul;
      int   pv;
      r = 1'b0;
      while (ready !== 1'b1) @(negedge clk);
      op = o;
      baddr = 14'(a);
      tcn = 9'(a);
      dmaddr = 11'(a);
      preset = 16'(p);
      from_dm = f;
      valid = 1'b1;
      b = bits.exists(a) ? bits[a] : 1'b0;
      pv = f ? dm[a] : (p > 9999 ? 9999 : p);
      case (o)
         4'h1, 4'h2: begin
            stk.push_back(m_cond);
            m_cond = b ^ (o == 4'h2);
         end
         4'h3: m_cond = m_cond & b;
         4'h4: m_cond = m_cond & ~b;
         4'h5: m_cond = m_cond | b;
         4'h6: m_cond = m_cond | ~b;
         4'h7: m_cond = stk.pop_back() & m_cond;
         4'h8: m_cond = stk.pop_back() | m_cond;
         4'h9: bits[a] = m_cond;
         4'hA: bits[a] = ~m_cond;
         4'hB: begin
            pul = stk.pop_back();
            if (m_cond)
               cnt[a] = pv;
            else if (pul && !lastp[a] && cnt[a] > 0)
               cnt[a]--;
            lastp[a] = pul;
            m_cond = !m_cond && cnt[a] == 0;
            bits['h3E00 + a] = m_cond;
         end
         4'hC: begin
            if (!m_cond)
               tim[a] = pv;
            else if (tstep && tim[a] > 0)
               tim[a]--;
            m_cond = m_cond && tim[a] == 0;
            bits['h3E00 + a] = m_cond;
         end
         4'hD: begin
            r = a >= 1000;
            if (!r)
               dm[a] = p;
         end
         // A scan longer than one tick period always holds a tick
         4'hE: begin
            tstep = (cycles - t_end) >= TICK;
            t_end = cycles;
         end
         default: ;
      endcase
      exp_q.push_back({m_cond, r});
      @(negedge clk);
   endtask

   // Pulse from the first loaded block, reset from the condition
   task automatic cnt_op(input int pa, input int ra, input int n, input int p, input bit f = 0);
      issue(4'h1, pa);
      issue(4'h1, ra);
      issue(4'hB, n, p, f);
   endtask

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      int s;
      logic [3:0] o;
      s = $urandom(32'h4743);
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      issue(4'h9, 0);
      issue(4'hA, 1);
      for (int i = 2; i < 16; i++) begin
         issue(4'h1, $urandom_range(1, 0));
         issue(4'h9, i);
         issue(4'h7, 0);
      end
      for (int i = 0; i < 120; i++) begin
         o = 4'($urandom_range(10, 1));
         if (o < 4'h3 && stk.size() == 8)
            o = 4'h3;
         if ((o == 4'h7 || o == 4'h8) && stk.size() == 0)
            o = 4'h6;
         // Bits 0 and 1 stay fixed for the counter scenarios
         issue(o, $urandom_range(15, 2));
      end
      while (stk.size() != 0)
         issue(4'h8, 0);
      issue(4'h0, 0);
      issue(4'hE, 0);
      // Each timer/counter number is used by one instruction type only
      cnt_op(0, 1, 5, 2);
      cnt_op(1, 0, 5, 2);
      cnt_op(0, 0, 5, 2);
      cnt_op(1, 0, 5, 2);
      cnt_op(1, 0, 5, 2);
      issue(4'h1, 'h3E05);
      issue(4'hD, 10, 0);
      issue(4'hD, 999, 1);
      issue(4'hD, 1000, 1);
      issue(4'hD, 1999, 3);
      cnt_op(0, 1, 10, 7, 1);
      cnt_op(0, 0, 10, 7, 1);
      // Every timer runs disabled once first, to load its present value
      issue(4'h1, 0);
      issue(4'hC, 3, 0);
      issue(4'h1, 1);
      issue(4'hC, 3, 0);
      issue(4'h1, 'h3E03);
      issue(4'h1, 0);
      issue(4'hC, 4, 5);
      issue(4'hC, 6, 1);
      issue(4'h1, 1);
      issue(4'hC, 4, 5);
      issue(4'hE, 0);
      issue(4'h1, 1);
      issue(4'hC, 6, 1);
      valid = 1'b0;
      repeat (4) @(negedge clk);
      if (exp_q.size() != 0)
         fail("results missing");
      stop_test();
   end
endmodule // ladder_bit_logic_engine_test
`default_nettype wire
